// File: perf_counter_top.sv
// Per-core event counters with APB register access
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - A core is active while running non-halt code or while being snooped.
// - Unhalted core, reference and serial cycle counts stop whenever halted, snooped or not.
// - Select bits 15:14 choose this core or, with 11b, all cores.
// - Unit mask bit 20h on bus events adds activity of every bus agent.
// - Qualifiers limit counting to the package or to the bus agent boundary.
// - Second-level refusal event counts each cycle the cache refuses requests.
// - Second-level idle event counts each cycle with no requests or prefetches issued.
// - Unhalted event with mask 00h counts every core clock while the core is not halted.
// - Unhalted event with mask 01h counts bus clocks while the core runs.
// - Mask 02h counts bus clocks when this core runs and the other halts.
// - Every first-level prefetch request counts, resubmitted ones included.
// - Every share snoop of the first-level data cache unit counts.
// - Bus idle event counts bus cycles with no transaction of this core pending.
// - Every clean, hit or modified-line reply to external snoops counts.
// - Each instruction byte fetch that misses the instruction cache counts.
module perf_counter_top #(
	parameter int CNT_N = 2,
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Conditions from the cores and the bus
	input wire perf_pkg::core_ev_t OWN_EV_I,
	input wire perf_pkg::core_ev_t OTHER_EV_I,
	input wire perf_pkg::bus_ev_t BUS_EV_I,
	input wire logic BUS_TICK_I,
	// State
	output logic CORE_ACTIVE_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	typedef enum logic [2:0] {
		DEC_NONE = 3'b001,
		DEC_SEL = 3'b010,
		DEC_CNT = 3'b100
	} dec_kind_t;

	typedef struct packed {
		logic hit;
		logic [31:0] data;
	} rd_t;

	perf_pkg::event_select_register_t sel_r [CNT_N];
	perf_pkg::event_select_register_t sel_nxt [CNT_N];
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic [CNT_N-1:0] wrap_r;
	logic [CNT_N-1:0] wrap_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic slverr_r;
	logic slverr_nxt;
	logic active_r;
	logic active_nxt;

	logic [CNT_W-1:0] cnt [CNT_N];
	logic [1:0] inc [CNT_N];
	logic [CNT_N-1:0] wrap_ev;
	logic [CNT_N-1:0] cnt_wr;
	logic setup_ph;
	logic access_wr;
	rd_t rd;

	////////////////////////////////////////////////////////////////////////////////
	// Address decoding
	function automatic dec_kind_t dec_kind(input logic [11:0] addr, input int idx);
		logic [11:0] sel_a;
		logic [11:0] cnt_a;
		sel_a = perf_pkg::OFF_SEL_BASE + 12'(idx) * perf_pkg::OFF_STRIDE;
		cnt_a = perf_pkg::OFF_CNT_BASE + 12'(idx) * perf_pkg::OFF_STRIDE;
		if (addr == sel_a) begin
			dec_kind = DEC_SEL;
		end else if (addr == cnt_a) begin
			dec_kind = DEC_CNT;
		end else begin
			dec_kind = DEC_NONE;
		end
	endfunction : dec_kind

	assign setup_ph = PSEL_I & ~PENABLE_I;
	assign access_wr = PSEL_I & PENABLE_I & PWRITE_I;

	////////////////////////////////////////////////////////////////////////////////
	// Counters
	for (genvar g = 0; g < CNT_N; g++) begin : g_cnt
		event_match u_match (
			.sel_i(sel_r[g]),
			.own_i(OWN_EV_I),
			.other_i(OTHER_EV_I),
			.bus_i(BUS_EV_I),
			.bus_tick_i(BUS_TICK_I),
			.inc_o(inc[g])
		);

		assign cnt_wr[g] = access_wr && (dec_kind(PADDR_I, g) == DEC_CNT);

		// Counting needs both the global run bit and the counter's own enable
		count_reg #(
			.CNT_W(CNT_W)
		) u_cnt (
			.clk_i(MCLK_I),
			.rst_n_i(RST_N_I),
			.en_i(ctrl_r[perf_pkg::CTRL_RUN_BIT] & sel_r[g].en),
			.inc_i(inc[g]),
			.wr_i(cnt_wr[g]),
			.wdata_i(PWDATA_I[CNT_W-1:0]),
			.cnt_o(cnt[g]),
			.wrap_o(wrap_ev[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux, evaluated in the setup phase so read data leaves a flip-flop
	always_comb begin
		rd.hit = 1'b0;
		rd.data = perf_pkg::WORD_ZERO;
		if (PADDR_I == perf_pkg::OFF_CTRL) begin
			rd.hit = 1'b1;
			rd.data = ctrl_r;
		end else if (PADDR_I == perf_pkg::OFF_STAT) begin
			rd.hit = 1'b1;
			rd.data[perf_pkg::STAT_OWN_ACT_BIT] = active_r;
			rd.data[perf_pkg::STAT_OWN_HALT_BIT] = OWN_EV_I.halted;
			rd.data[perf_pkg::STAT_OTH_HALT_BIT] = OTHER_EV_I.halted;
		end else if (PADDR_I == perf_pkg::OFF_WRAP) begin
			rd.hit = 1'b1;
			rd.data[CNT_N-1:0] = wrap_r;
		end else begin
			for (int i = 0; i < CNT_N; i++) begin
				if (dec_kind(PADDR_I, i) == DEC_SEL) begin
					rd.hit = 1'b1;
					rd.data = sel_r[i];
				end else if (dec_kind(PADDR_I, i) == DEC_CNT) begin
					rd.hit = 1'b1;
					rd.data[CNT_W-1:0] = cnt[i];
				end
			end
		end
		// Misaligned addresses are answered as unmapped
		if ((PADDR_I & perf_pkg::OFF_WORD_MASK) != 12'h000) begin
			rd.hit = 1'b0;
			rd.data = perf_pkg::WORD_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register next state
	always_comb begin
		ctrl_nxt = ctrl_r;
		wrap_nxt = wrap_r;
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		active_nxt = ~OWN_EV_I.halted | OWN_EV_I.snooped;
		for (int i = 0; i < CNT_N; i++) begin
			sel_nxt[i] = sel_r[i];
			if (access_wr && (dec_kind(PADDR_I, i) == DEC_SEL)) begin
				sel_nxt[i] = PWDATA_I & perf_pkg::SEL_WMASK;
			end
		end
		if (access_wr && (PADDR_I == perf_pkg::OFF_CTRL)) begin
			ctrl_nxt = PWDATA_I & (32'h00000001 << perf_pkg::CTRL_RUN_BIT);
		end
		// Write-one-to-clear; a wrap in the same cycle keeps the flag set
		if (access_wr && (PADDR_I == perf_pkg::OFF_WRAP)) begin
			wrap_nxt = wrap_nxt & ~PWDATA_I[CNT_N-1:0];
		end
		wrap_nxt = wrap_nxt | wrap_ev;
		if (setup_ph) begin
			prdata_nxt = PWRITE_I ? perf_pkg::WORD_ZERO : rd.data;
			slverr_nxt = ~rd.hit;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < CNT_N; i++) begin
				sel_r[i] <= perf_pkg::SEL_RST;
			end
			ctrl_r <= perf_pkg::CTRL_RST;
			wrap_r <= '0;
			prdata_r <= perf_pkg::WORD_ZERO;
			slverr_r <= 1'b0;
			active_r <= 1'b0;
		end else begin
			for (int i = 0; i < CNT_N; i++) begin
				sel_r[i] <= sel_nxt[i];
			end
			ctrl_r <= ctrl_nxt;
			wrap_r <= wrap_nxt;
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
			active_r <= active_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign PRDATA_O = prdata_r;
	assign PREADY_O = PSEL_I & PENABLE_I;
	assign PSLVERR_O = PSEL_I & PENABLE_I & slverr_r;
	assign CORE_ACTIVE_O = active_r;

endmodule : perf_counter_top
`default_nettype wire

// File: perf_pkg.sv
// Constants, register map and signal bundles of the per-core event counting block
package perf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map (byte offsets)
	localparam logic [11:0] OFF_SEL_BASE = 12'h000;
	localparam logic [11:0] OFF_CNT_BASE = 12'h004;
	localparam logic [11:0] OFF_STRIDE = 12'h008;
	localparam logic [11:0] OFF_CTRL = 12'h040;
	localparam logic [11:0] OFF_STAT = 12'h044;
	localparam logic [11:0] OFF_WRAP = 12'h048;
	localparam logic [11:0] OFF_WORD_MASK = 12'h003;

	////////////////////////////////////////////////////////////////////////////////
	// Field layouts and reset values
	localparam logic [31:0] SEL_WMASK = 32'h0040ffff;
	localparam logic [31:0] SEL_RST = 32'h00000000;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_OWN_ACT_BIT = 0;
	localparam int STAT_OWN_HALT_BIT = 1;
	localparam int STAT_OTH_HALT_BIT = 2;
	localparam int UM_AGENT_IDX = 5;
	localparam logic [1:0] SPEC_ALL = 2'h3;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	// Event codes and unit masks
	localparam logic [7:0] EV_L2_REFUSE = 8'h30;
	localparam logic [7:0] EV_L2_IDLE = 8'h32;
	localparam logic [7:0] EV_UNHALTED = 8'h3c;
	localparam logic [7:0] EV_L1_PREFETCH = 8'h4f;
	localparam logic [7:0] EV_SNOOP_REPLY = 8'h77;
	localparam logic [7:0] EV_SHARE_SNOOP = 8'h78;
	localparam logic [7:0] EV_BUS_IDLE = 8'h7d;
	localparam logic [7:0] EV_IFETCH_MISS = 8'h81;
	localparam logic [7:0] UM_CORE_CYC = 8'h00;
	localparam logic [7:0] UM_REF_CYC = 8'h01;
	localparam logic [7:0] UM_SERIAL_CYC = 8'h02;
	localparam logic [1:0] INC_NONE = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Bundles
	typedef struct packed {
		logic [8:0] rsvd_hi;
		logic en;
		logic [5:0] rsvd_mid;
		logic [1:0] spec;
		logic [5:0] um_lo;
		logic [7:0] evt;
	} event_select_register_t;

	typedef struct packed {
		logic halted;
		logic snooped;
		logic l2_refuse;
		logic l2_idle;
		logic l1_prefetch;
		logic share_snoop;
		logic bus_idle;
		logic snoop_reply;
		logic ifetch_miss;
	} core_ev_t;

	typedef struct packed {
		logic agents_idle;
		logic agents_snoop_reply;
	} bus_ev_t;

endpackage : perf_pkg

// File: event_match.sv
// Event qualifier: turns one event selection and the raw conditions into an increment
`timescale 1ns/10ps
`default_nettype none
module event_match (
	// Selection
	input wire perf_pkg::event_select_register_t sel_i,
	// Conditions
	input wire perf_pkg::core_ev_t own_i,
	input wire perf_pkg::core_ev_t other_i,
	input wire perf_pkg::bus_ev_t bus_i,
	input wire logic bus_tick_i,
	// Increment
	output logic [1:0] inc_o
);

	logic own_act;
	logic oth_act;
	logic spec_all;
	logic agents;
	logic [7:0] umask;

	// Counts this core, or both cores of the package when all cores are chosen
	function automatic logic [1:0] pick(input logic own_c, input logic oth_c, input logic both);
		pick = both ? ({1'b0, own_c} + {1'b0, oth_c}) : {1'b0, own_c};
	endfunction : pick

	assign own_act = ~own_i.halted | own_i.snooped;
	assign oth_act = ~other_i.halted | other_i.snooped;
	assign spec_all = (sel_i.spec == perf_pkg::SPEC_ALL);
	assign agents = sel_i.um_lo[perf_pkg::UM_AGENT_IDX];
	assign umask = {sel_i.spec, sel_i.um_lo};

	always_comb begin
		inc_o = perf_pkg::INC_NONE;
		case (sel_i.evt)
			perf_pkg::EV_L2_REFUSE: begin
				inc_o = pick(own_i.l2_refuse & own_act, other_i.l2_refuse & oth_act, spec_all);
			end
			perf_pkg::EV_L2_IDLE: begin
				inc_o = pick(own_i.l2_idle & own_act, other_i.l2_idle & oth_act, spec_all);
			end
			perf_pkg::EV_UNHALTED: begin
				// Snoop activity does not wake these three up: halted means no count
				case (umask)
					perf_pkg::UM_CORE_CYC: inc_o = {1'b0, ~own_i.halted};
					perf_pkg::UM_REF_CYC: inc_o = {1'b0, bus_tick_i & ~own_i.halted};
					perf_pkg::UM_SERIAL_CYC: begin
						inc_o = {1'b0, bus_tick_i & ~own_i.halted & other_i.halted};
					end
					default: inc_o = perf_pkg::INC_NONE;
				endcase
			end
			perf_pkg::EV_L1_PREFETCH: begin
				// Each resubmission after a refusal arrives as a fresh request
				inc_o = pick(own_i.l1_prefetch & own_act, other_i.l1_prefetch & oth_act, spec_all);
			end
			perf_pkg::EV_SHARE_SNOOP: begin
				inc_o = pick(own_i.share_snoop & own_act, other_i.share_snoop & oth_act, spec_all);
			end
			perf_pkg::EV_BUS_IDLE: begin
				inc_o = {1'b0, bus_tick_i & own_i.bus_idle & (~agents | bus_i.agents_idle)};
			end
			perf_pkg::EV_SNOOP_REPLY: begin
				inc_o = pick(own_i.snoop_reply, other_i.snoop_reply, spec_all) + {1'b0, agents & bus_i.agents_snoop_reply};
			end
			perf_pkg::EV_IFETCH_MISS: begin
				inc_o = pick(own_i.ifetch_miss & own_act, other_i.ifetch_miss & oth_act, spec_all);
			end
			default: inc_o = perf_pkg::INC_NONE;
		endcase
	end

endmodule : event_match
`default_nettype wire

// File: count_reg.sv
// One event counter with software preset and a wrap pulse
`timescale 1ns/10ps
`default_nettype none
module count_reg #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Counting
	input wire logic en_i,
	input wire logic [1:0] inc_i,
	// Preset
	input wire logic wr_i,
	input wire logic [CNT_W-1:0] wdata_i,
	// State
	output logic [CNT_W-1:0] cnt_o,
	output logic wrap_o
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] base;
	logic [CNT_W:0] sum;

	always_comb begin
		// A preset in the same cycle as an event keeps the event
		base = wr_i ? wdata_i : cnt_r;
		sum = {1'b0, base} + {{(CNT_W - 1){1'b0}}, (en_i ? inc_i : perf_pkg::INC_NONE)};
		cnt_nxt = sum[CNT_W-1:0];
		wrap_o = sum[CNT_W];
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt_o = cnt_r;

endmodule : count_reg
`default_nettype wire

// File: bus_tick_model.sv
// Far-side bus clock model: a one-cycle tick every RATIO core clocks
`timescale 1ns/10ps
`default_nettype none
module bus_tick_model #(
	parameter int RATIO = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bus clock strobe
	output logic tick_o
);
	logic [7:0] cnt_r;
	// Core clock runs a fixed ratio faster than the bus clock
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_r <= 8'h00;
			tick_o <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == 8'(RATIO - 1)) ? 8'h00 : cnt_r + 8'h01;
			tick_o <= (cnt_r == 8'(RATIO - 1));
		end
	end
endmodule : bus_tick_model
`default_nettype wire

// File: perf_counter_sva.sv
// Port checker of the event counting block
`timescale 1ns/10ps
`default_nettype none
module perf_counter_sva (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// APB
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// Cores
	input wire perf_pkg::core_ev_t OWN_EV_I,
	input wire perf_pkg::core_ev_t OTHER_EV_I,
	input wire logic CORE_ACTIVE_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	////////////////////////////////////////////////////////////////////////////////
	chk_ready_access: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
		else $error("pready low in access phase");
	chk_ready_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PREADY_O)
		else $error("pready high outside access phase");
	chk_err_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
		else $error("pslverr outside access phase");
	chk_bad_addr_err: assert property (PSEL_I && !PENABLE_I && (PADDR_I > 12'h048 || PADDR_I[1:0] != 2'h0)
		##1 PENABLE_I |-> PSLVERR_O) else $error("unmapped address not refused");
	chk_good_addr_ok: assert property (PSEL_I && !PENABLE_I && (PADDR_I inside {12'h040, 12'h044, 12'h048})
		##1 PENABLE_I |-> !PSLVERR_O) else $error("mapped address refused");
	chk_err_read_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h00000000)
		else $error("refused read returned data");
	chk_write_data_zero: assert property (PSEL_I && PENABLE_I && PWRITE_I |-> PRDATA_O == 32'h00000000)
		else $error("read data driven during write");
	chk_core_active: assert property ($past(RST_N_I) |->
		CORE_ACTIVE_O == $past(!OWN_EV_I.halted || OWN_EV_I.snooped)) else $error("core active wrong");
	chk_stat_halts: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == 12'h044
		|=> PRDATA_O[2:1] == $past({OTHER_EV_I.halted, OWN_EV_I.halted})) else $error("status halts wrong");
endmodule : perf_counter_sva
bind perf_counter_top perf_counter_sva chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .OWN_EV_I(OWN_EV_I), .OTHER_EV_I(OTHER_EV_I), .CORE_ACTIVE_O(CORE_ACTIVE_O));
`default_nettype wire

// File: perf_counter_top_bench.sv
// Self-checking bench of the event counting block
`timescale 1ns/10ps
`default_nettype none
module perf_counter_top_bench;
	logic MCLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic PSEL_I = 1'b0;
	logic PENABLE_I = 1'b0;
	logic PWRITE_I = 1'b0;
	logic [11:0] PADDR_I = 12'h000;
	logic [31:0] PWDATA_I = 32'h00000000;
	logic [31:0] PRDATA_O;
	logic PREADY_O;
	logic PSLVERR_O;
	// Idle keeps both cores halted so that no event can slip into a count
	perf_pkg::core_ev_t OWN_EV_I = 9'h100;
	perf_pkg::core_ev_t OTHER_EV_I = 9'h100;
	perf_pkg::bus_ev_t BUS_EV_I = 2'h0;
	logic BUS_TICK_I;
	logic CORE_ACTIVE_O;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] q;
	logic e;

	perf_counter_top uut (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
		.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
		.PSLVERR_O(PSLVERR_O), .OWN_EV_I(OWN_EV_I), .OTHER_EV_I(OTHER_EV_I), .BUS_EV_I(BUS_EV_I),
		.BUS_TICK_I(BUS_TICK_I), .CORE_ACTIVE_O(CORE_ACTIVE_O));
	bus_tick_model #(.RATIO(3)) bus (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .tick_o(BUS_TICK_I));

	always #12.5 MCLK_I = ~MCLK_I;
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	always @(posedge MCLK_I) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge MCLK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= wr;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge MCLK_I);
		PENABLE_I <= 1'b1;
		// Waits as long as the slave needs; only the bench timeout ends a hang
		do begin
			@(posedge MCLK_I);
		end while (PREADY_O !== 1'b1);
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask : apb

	// Presets counter 0, applies the conditions for n clocks, then reads the count back
	task run_ev(input logic [31:0] sel, input logic [8:0] own, input logic [8:0] oth, input logic [1:0] bev,
		input int n, input logic [31:0] pc, input logic [31:0] pt, input logic [31:0] pre);
		logic [31:0] ticks;
		ticks = 32'h0;
		apb(1'b1, 12'h000, sel, q, e);
		apb(1'b1, 12'h004, pre, q, e);
		@(posedge MCLK_I);
		OWN_EV_I <= own;
		OTHER_EV_I <= oth;
		BUS_EV_I <= bev;
		repeat (n) begin
			@(negedge MCLK_I);
			ticks += 32'(BUS_TICK_I);
			@(posedge MCLK_I);
		end
		OWN_EV_I <= 9'h100;
		OTHER_EV_I <= 9'h100;
		BUS_EV_I <= 2'h0;
		// Activity is registered, so the last applied cycle shows up half a clock later
		@(negedge MCLK_I);
		check({31'h0, CORE_ACTIVE_O}, {31'h0, ~own[8] | own[7]});
		apb(1'b0, 12'h004, 32'h0, q, e);
		check(q, pre + pc * n + pt * ticks);
	endtask : run_ev

	task regs_after_reset;
		apb(1'b0, 12'h000, 32'h0, q, e);
		check(q, 32'h00000000);
		apb(1'b0, 12'h004, 32'h0, q, e);
		check(q, 32'h00000000);
		apb(1'b0, 12'h044, 32'h0, q, e);
		check(q, 32'h00000006);
		apb(1'b1, 12'h044, 32'hffffffff, q, e);
		check({31'h0, e}, 32'h0);
		apb(1'b0, 12'h04c, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		apb(1'b1, 12'h002, 32'h1, q, e);
		check({31'h0, e}, 32'h1);
		apb(1'b1, 12'h00c, 32'h0000abcd, q, e);
		apb(1'b0, 12'h00c, 32'h0, q, e);
		check(q, 32'h0000abcd);
		apb(1'b1, 12'h040, 32'h1, q, e);
		apb(1'b0, 12'h040, 32'h0, q, e);
		check(q, 32'h00000001);
	endtask : regs_after_reset

	task wrap_and_clear;
		run_ev(32'h00400030, 9'h040, 9'h100, 2'h0, 2, 1, 0, 32'hffffffff);
		apb(1'b0, 12'h048, 32'h0, q, e);
		check(q, 32'h00000001);
		apb(1'b1, 12'h048, 32'h1, q, e);
		apb(1'b0, 12'h048, 32'h0, q, e);
		check(q, 32'h00000000);
	endtask : wrap_and_clear

	initial begin
		repeat (5) @(posedge MCLK_I);
		RST_N_I <= 1'b1;
		regs_after_reset();
		run_ev(32'h00400030, 9'h040, 9'h100, 2'h0, 6, 1, 0, 32'h10);
		run_ev(32'h00000030, 9'h040, 9'h100, 2'h0, 6, 0, 0, 32'h10);
		run_ev(32'h00400030, 9'h140, 9'h100, 2'h0, 6, 0, 0, 32'h0);
		run_ev(32'h00400030, 9'h1c0, 9'h100, 2'h0, 6, 1, 0, 32'h0);
		run_ev(32'h0040c030, 9'h040, 9'h040, 2'h0, 6, 2, 0, 32'h0);
		run_ev(32'h00400032, 9'h020, 9'h100, 2'h0, 6, 1, 0, 32'h0);
		run_ev(32'h0040004f, 9'h010, 9'h100, 2'h0, 6, 1, 0, 32'h0);
		run_ev(32'h00400178, 9'h008, 9'h100, 2'h0, 6, 1, 0, 32'h0);
		run_ev(32'h00400081, 9'h001, 9'h100, 2'h0, 6, 1, 0, 32'h0);
		run_ev(32'h0040003c, 9'h180, 9'h100, 2'h0, 6, 0, 0, 32'h0);
		run_ev(32'h0040003c, 9'h000, 9'h100, 2'h0, 7, 1, 0, 32'h0);
		run_ev(32'h0040013c, 9'h000, 9'h100, 2'h0, 7, 0, 1, 32'h0);
		run_ev(32'h0040023c, 9'h000, 9'h100, 2'h0, 7, 0, 1, 32'h0);
		run_ev(32'h0040023c, 9'h000, 9'h000, 2'h0, 7, 0, 0, 32'h0);
		run_ev(32'h0040007d, 9'h004, 9'h100, 2'h0, 7, 0, 1, 32'h0);
		run_ev(32'h0040207d, 9'h004, 9'h100, 2'h0, 7, 0, 0, 32'h0);
		run_ev(32'h0040207d, 9'h004, 9'h100, 2'h2, 7, 0, 1, 32'h0);
		run_ev(32'h00400077, 9'h102, 9'h100, 2'h0, 6, 1, 0, 32'h0);
		run_ev(32'h00402077, 9'h100, 9'h100, 2'h1, 6, 1, 0, 32'h0);
		wrap_and_clear();
		end_sim();
	end
endmodule : perf_counter_top_bench
`default_nettype wire
